/* File: hdl/trace_mode_and_fill_level_regs.sv */
// Register group: operating mode, fill levels, watermark and upper pointers
//
// Functional notes
// - Mode field decodes circular, software, hardware FIFO
// - Mode written in any state; steering only when not disabled
// - Hardware FIFO stalls when full, drains when non-empty; on-chip FIFO configuration only
// - Software FIFO readable while capturing; stalls when full
// - Circular starts at write pointer, overwrites
// - Peak level read returns max, reloads current
// - Peak level reads zero under scatter-gather in the system memory configuration
// - Peak held while disabled; cleared leaving disabled
// - Locked peak read returns zero, no update
// - Peak width depends on configuration
// - Current level reads zero when capture off
// - Current level reads zero under scatter-gather in the system memory configuration
// - Fill reaching depth minus watermark signals full
// - Watermark only in FIFO modes, not system memory scatter-gather
// - Circular mode sets full on pointer wrap
// - Watermark max depth minus one; full first word
// - Read address uses upper read pointer bits
// - Write address uses upper write pointer bits
// - Control bit zero is capture enable
// - Write pointer wrap sets status full flag
`timescale 1ns/1ps

module trace_mode_and_fill_level_regs
  import trace_regs_pkg::*;
#(
  parameter trace_regs_pkg::mem_config_t MEM_CONFIG = trace_regs_pkg::CFG_ONCHIP_FIFO
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire trace_regs_pkg::reg_req_t reg_req,
  output trace_regs_pkg::reg_rsp_t reg_rsp,
  // Control state from the capture datapath
  input wire logic locked,
  input wire logic disabled_state,
  input wire logic scatter_gather,
  input wire logic [trace_regs_pkg::LEVEL_W-1:0] fill_level,
  input wire logic write_pointer_wrap,
  input wire logic [trace_regs_pkg::PTR_W-1:0] read_pointer_lower,
  input wire logic [trace_regs_pkg::PTR_W-1:0] write_pointer_lower,
  // Steering outputs
  output logic capture_enable,
  output trace_regs_pkg::op_mode_t active_mode,
  output trace_regs_pkg::mode_ctl_t mode_ctl,
  output logic full_out,
  output trace_regs_pkg::wide_addr_t wide_addr
);
  import trace_regs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic capture_enable;
    logic [MODE_W-1:0] mode;
    logic [31:0] watermark;
    logic [PTR_HI_W-1:0] rp_upper;
    logic [PTR_HI_W-1:0] wp_upper;
    logic [SYS_LEVEL_W-1:0] peak;
    logic full_flag;
    logic disabled_d;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  localparam bit SYS_MEM = (MEM_CONFIG == CFG_SYSTEM_MEMORY);
  localparam int PEAK_W = SYS_MEM ? SYS_LEVEL_W : LEVEL_W;
  localparam logic [SYS_LEVEL_W-1:0] PEAK_MASK = SYS_LEVEL_W'((64'h1 << PEAK_W) - 64'h1);
  localparam logic [31:0] DEPTH_WORDS = 32'(MEM_DEPTH);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic access;
  logic wr_acc;
  logic rd_acc;
  logic [SYS_LEVEL_W-1:0] level_ext;
  logic [31:0] level_word;
  logic wm_full;
  logic mode_active;
  op_mode_t mode_dec;
  logic mapped;

  assign access = reg_req.sel && reg_req.enable;
  assign wr_acc = access && reg_req.write;
  assign rd_acc = access && !reg_req.write;
  assign level_ext = SYS_LEVEL_W'(fill_level);
  assign level_word = 32'(fill_level);
  assign mode_active = !disabled_state;

  always_comb
  begin
    unique case (s_r.mode)
      2'h0: mode_dec = MODE_CIRCULAR;
      2'h1: mode_dec = MODE_SW_FIFO;
      2'h2: mode_dec = MODE_HW_FIFO;
      2'h3: mode_dec = MODE_RESERVED;
    endcase
  end

  // full when fill >= depth minus watermark; max gives first word
  assign wm_full = (level_word != ZERO_WORD) &&
                   ({1'b0, level_word} >= ({1'b0, DEPTH_WORDS} - {1'b0, s_r.watermark}));

  assign mapped = hit(reg_req.addr, OFS_CONTROL) || hit(reg_req.addr, OFS_MODE) ||
                  hit(reg_req.addr, OFS_PEAK_LEVEL) || hit(reg_req.addr, OFS_CURRENT_LEVEL) ||
                  hit(reg_req.addr, OFS_WATERMARK) || hit(reg_req.addr, OFS_STATUS) ||
                  hit(reg_req.addr, OFS_READ_POINTER_UPPER) ||
                  hit(reg_req.addr, OFS_WRITE_POINTER_UPPER);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.disabled_d = disabled_state;
    s_nxt.slverr = 1'b0;

    // peak tracking only while running; cleared on leaving disabled
    if (s_r.disabled_d && !disabled_state)
    begin
      s_nxt.peak = '0;
    end
    else if (mode_active && (level_ext > s_r.peak))
    begin
      s_nxt.peak = level_ext & PEAK_MASK;
    end

    // wrap of the write pointer sets full; covers circular mode
    if (wm_full && mode_active && !(SYS_MEM && scatter_gather) &&
        (mode_dec == MODE_SW_FIFO || mode_dec == MODE_HW_FIFO))
    begin
      s_nxt.full_flag = 1'b1;
    end
    else if (write_pointer_wrap)
    begin
      s_nxt.full_flag = 1'b1;
    end
    else if (s_r.disabled_d && !disabled_state)
    begin
      s_nxt.full_flag = 1'b0;
    end

    if (wr_acc)
    begin
      // capture enable from control bit 0
      if (hit(reg_req.addr, OFS_CONTROL))
        s_nxt.capture_enable = reg_req.wdata[CAPTURE_ENABLE_BIT];
      // software writes mode and watermark in any state
      if (hit(reg_req.addr, OFS_MODE))
        s_nxt.mode = reg_req.wdata[MODE_W-1:0];
      if (hit(reg_req.addr, OFS_WATERMARK))
        s_nxt.watermark = reg_req.wdata & 32'(MEM_DEPTH - 1);
      if (hit(reg_req.addr, OFS_READ_POINTER_UPPER))
        s_nxt.rp_upper = reg_req.wdata[PTR_HI_W-1:0];
      if (hit(reg_req.addr, OFS_WRITE_POINTER_UPPER))
        s_nxt.wp_upper = reg_req.wdata[PTR_HI_W-1:0];
    end

    s_nxt.rdata = ZERO_WORD;
    if (rd_acc)
    begin
      s_nxt.slverr = !mapped;
      unique case (1'b1)
        hit(reg_req.addr, OFS_CONTROL):
          s_nxt.rdata = {31'h0, s_r.capture_enable};
        hit(reg_req.addr, OFS_MODE):
          s_nxt.rdata = {30'h0, s_r.mode};
        hit(reg_req.addr, OFS_STATUS):
          s_nxt.rdata = {31'h0, s_r.full_flag};
        hit(reg_req.addr, OFS_WATERMARK):
          s_nxt.rdata = s_r.watermark;
        hit(reg_req.addr, OFS_READ_POINTER_UPPER):
          s_nxt.rdata = {24'h0, s_r.rp_upper};
        hit(reg_req.addr, OFS_WRITE_POINTER_UPPER):
          s_nxt.rdata = {24'h0, s_r.wp_upper};
        hit(reg_req.addr, OFS_CURRENT_LEVEL):
        begin
          // zero when capture off; zero under scatter-gather with system memory
          if (s_r.capture_enable && !(SYS_MEM && scatter_gather))
            s_nxt.rdata = level_word;
        end
        hit(reg_req.addr, OFS_PEAK_LEVEL):
        begin
          // system memory scatter-gather and lock both read zero
          if (!locked && !(SYS_MEM && scatter_gather))
          begin
            s_nxt.rdata = {1'b0, s_r.peak & PEAK_MASK};
            // reload with present level on read
            if (mode_active)
              s_nxt.peak = level_ext & PEAK_MASK;
          end
        end
        default:
          s_nxt.rdata = ZERO_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.capture_enable <= 1'b0;
      s_r.mode <= MODE_RESET;
      s_r.watermark <= WATERMARK_RESET;
      s_r.rp_upper <= PTR_HI_RESET;
      s_r.wp_upper <= PTR_HI_RESET;
      s_r.peak <= '0;
      s_r.full_flag <= 1'b0;
      s_r.disabled_d <= 1'b1;
      s_r.rdata <= ZERO_WORD;
      s_r.slverr <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rsp.ready = 1'b1;
  assign reg_rsp.rdata = s_r.rdata;
  assign reg_rsp.slverr = s_r.slverr;
  assign capture_enable = s_r.capture_enable;
  assign active_mode = mode_dec;

  always_comb
  begin
    mode_ctl = '0;
    if (mode_active)
    begin
      // circular overwrites from the write pointer
      mode_ctl.circular = (mode_dec == MODE_CIRCULAR);
      mode_ctl.sw_fifo = (mode_dec == MODE_SW_FIFO);
      // hardware FIFO stalls on full, drains when non-empty
      // honoured only in the on-chip FIFO configuration
      mode_ctl.hw_fifo = (mode_dec == MODE_HW_FIFO) && (MEM_CONFIG == CFG_ONCHIP_FIFO);
      mode_ctl.stall_in = (mode_ctl.sw_fifo || mode_ctl.hw_fifo) &&
                          (fill_level >= LEVEL_W'(MEM_DEPTH));
      mode_ctl.drain_out = mode_ctl.hw_fifo && (fill_level != '0);
    end
    mode_ctl.full = s_r.full_flag;
  end

  // full output mirrors the status flag
  assign full_out = s_r.full_flag;

  // wide read address; wide write address
  assign wide_addr.rd_addr = {s_r.rp_upper, read_pointer_lower};
  assign wide_addr.wr_addr = {s_r.wp_upper, write_pointer_lower};

endmodule

/* File: include/trace_regs_pkg.sv */
// Package for the trace mode and fill level register group
package trace_regs_pkg;

  // ----------------------------------------------------------------
  // Configuration and sizes
  // ----------------------------------------------------------------
  localparam int MEM_DEPTH_LOG2 = 10;
  localparam int MEM_DEPTH = 1 << MEM_DEPTH_LOG2;
  localparam int LEVEL_W = MEM_DEPTH_LOG2 + 1;
  localparam int SYS_LEVEL_W = 31;
  localparam int PTR_W = 32;
  localparam int PTR_HI_W = 8;
  localparam int ADDR_W = PTR_W + PTR_HI_W;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_WRITE_POINTER_LOWER = 12'h018;
  localparam logic [11:0] OFS_CONTROL = 12'h020;
  localparam logic [11:0] OFS_MODE = 12'h028;
  localparam logic [11:0] OFS_PEAK_LEVEL = 12'h02c;
  localparam logic [11:0] OFS_CURRENT_LEVEL = 12'h030;
  localparam logic [11:0] OFS_WATERMARK = 12'h034;
  localparam logic [11:0] OFS_READ_POINTER_UPPER = 12'h038;
  localparam logic [11:0] OFS_WRITE_POINTER_UPPER = 12'h03c;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_READ_POINTER_LOWER = 12'h014;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CAPTURE_ENABLE_BIT = 0;
  localparam int STATUS_FULL_BIT = 0;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
  localparam logic [31:0] WATERMARK_RESET = 32'h0000_0000;
  localparam logic [PTR_HI_W-1:0] PTR_HI_RESET = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [MODE_W-1:0] {
    MODE_CIRCULAR = 2'h0,
    MODE_SW_FIFO = 2'h1,
    MODE_HW_FIFO = 2'h2,
    MODE_RESERVED = 2'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    CFG_ONCHIP_BUFFER = 2'h0,
    CFG_ONCHIP_FIFO = 2'h1,
    CFG_SYSTEM_MEMORY = 2'h2
  } mem_config_t;

  // Register port request
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Register port answer
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } reg_rsp_t;

  // Decoded steering for the capture datapath
  typedef struct packed {
    logic circular;
    logic sw_fifo;
    logic hw_fifo;
    logic stall_in;
    logic drain_out;
    logic full;
  } mode_ctl_t;

  // Wide addresses toward the memory interface
  typedef struct packed {
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
  } wide_addr_t;

endpackage

/* File: verification/trace_regs_props.sv */
// Concurrent checks on the trace mode and fill level register group
`timescale 1ns/1ps
module trace_regs_props
  import trace_regs_pkg::*;
#(
  parameter trace_regs_pkg::mem_config_t MEM_CONFIG = trace_regs_pkg::CFG_ONCHIP_FIFO
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire trace_regs_pkg::reg_req_t reg_req,
  input wire trace_regs_pkg::reg_rsp_t reg_rsp,
  // Datapath state
  input wire logic locked,
  input wire logic disabled_state,
  input wire logic scatter_gather,
  input wire logic [trace_regs_pkg::LEVEL_W-1:0] fill_level,
  input wire logic write_pointer_wrap,
  input wire logic [trace_regs_pkg::PTR_W-1:0] read_pointer_lower,
  input wire logic [trace_regs_pkg::PTR_W-1:0] write_pointer_lower,
  // Steering outputs
  input wire logic capture_enable,
  input wire trace_regs_pkg::op_mode_t active_mode,
  input wire trace_regs_pkg::mode_ctl_t mode_ctl,
  input wire logic full_out,
  input wire trace_regs_pkg::wide_addr_t wide_addr
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic rd;
  logic wr;
  assign rd = reg_req.sel && reg_req.enable && !reg_req.write;
  assign wr = reg_req.sel && reg_req.enable && reg_req.write;

  a_rd_addr_join: assert property (wr && reg_req.addr == OFS_READ_POINTER_UPPER |=>
    wide_addr.rd_addr == {$past(reg_req.wdata[7:0]), read_pointer_lower})
    else $error("read address upper bits wrong");
  a_wr_addr_join: assert property (wr && reg_req.addr == OFS_WRITE_POINTER_UPPER |=>
    wide_addr.wr_addr == {$past(reg_req.wdata[7:0]), write_pointer_lower})
    else $error("write address upper bits wrong");
  a_mode_idle: assert property (disabled_state |->
    !(mode_ctl.circular || mode_ctl.sw_fifo || mode_ctl.hw_fifo))
    else $error("mode steering active while disabled");
  a_wrap_full: assert property (write_pointer_wrap |=> full_out)
    else $error("pointer wrap did not set full");
  a_cur_level: assert property (rd && reg_req.addr == OFS_CURRENT_LEVEL |=>
    reg_rsp.rdata == (($past(capture_enable) &&
      !(MEM_CONFIG == CFG_SYSTEM_MEMORY && $past(scatter_gather))) ?
      32'($past(fill_level)) : 32'h0))
    else $error("current level read wrong");
  a_peak_locked: assert property (rd && reg_req.addr == OFS_PEAK_LEVEL && locked |=>
    reg_rsp.rdata == 32'h0)
    else $error("locked peak read not zero");
  a_mode_rsvd: assert property (rd && reg_req.addr == OFS_MODE |=>
    reg_rsp.rdata[31:2] == 30'h0)
    else $error("mode reserved bits not zero");
  a_sw_decode: assert property (!disabled_state && active_mode == MODE_SW_FIFO |->
    mode_ctl.sw_fifo && !mode_ctl.circular && !mode_ctl.hw_fifo)
    else $error("software fifo mode not decoded");
endmodule

bind trace_mode_and_fill_level_regs trace_regs_props #(.MEM_CONFIG(MEM_CONFIG)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .locked(locked),
  .disabled_state(disabled_state), .scatter_gather(scatter_gather), .fill_level(fill_level),
  .write_pointer_wrap(write_pointer_wrap), .read_pointer_lower(read_pointer_lower),
  .write_pointer_lower(write_pointer_lower), .capture_enable(capture_enable),
  .active_mode(active_mode), .mode_ctl(mode_ctl), .full_out(full_out), .wide_addr(wide_addr));

/* File: verification/tb_top.sv */
// Self-checking bench for the trace mode and fill level register group
`timescale 1ns/1ps
module tb_top;
  import trace_regs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  reg_rsp_t reg_rsp;
  logic locked = 1'b0;
  logic disabled_state = 1'b1;
  logic scatter_gather = 1'b0;
  logic [LEVEL_W-1:0] fill_level = '0;
  logic write_pointer_wrap = 1'b0;
  logic [PTR_W-1:0] read_pointer_lower = '0;
  logic [PTR_W-1:0] write_pointer_lower = '0;
  logic capture_enable;
  op_mode_t active_mode;
  mode_ctl_t mode_ctl;
  logic full_out;
  wide_addr_t wide_addr;
  logic taken = 1'b0;
  logic [64:0] n;
  logic [64:0] notes[$];
  logic sys_on = 1'b0;
  reg_rsp_t rsp_sys;
  logic full_sys;
  logic [31:0] r;
  int miscompares = 0;
  int checked = 0;

  always #5 core_clk = ~core_clk;

  trace_mode_and_fill_level_regs dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .locked(locked),
    .disabled_state(disabled_state), .scatter_gather(scatter_gather), .fill_level(fill_level),
    .write_pointer_wrap(write_pointer_wrap), .read_pointer_lower(read_pointer_lower),
    .write_pointer_lower(write_pointer_lower), .capture_enable(capture_enable),
    .active_mode(active_mode), .mode_ctl(mode_ctl), .full_out(full_out), .wide_addr(wide_addr));

  // System memory instance; it sees the port only once no hardware FIFO mode is written
  trace_mode_and_fill_level_regs #(.MEM_CONFIG(CFG_SYSTEM_MEMORY)) dut_sys (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(sys_on ? reg_req : reg_req_t'('0)),
    .reg_rsp(rsp_sys), .locked(locked), .disabled_state(disabled_state),
    .scatter_gather(scatter_gather), .fill_level(fill_level),
    .write_pointer_wrap(write_pointer_wrap), .read_pointer_lower(read_pointer_lower),
    .write_pointer_lower(write_pointer_lower), .capture_enable(), .active_mode(),
    .mode_ctl(), .full_out(full_sys), .wide_addr());

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, exp, m);
    checked++;
    if ((got & m) !== (exp & m))
    begin
      miscompares++;
      $display("unexpected read at %0t: %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected flag at %0t: %b not %b", $time, got, exp);
    end
  endtask

  // One access; a read notes its expected data and mask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, m);
    if (!w)
      notes.push_back({!(a inside {OFS_CONTROL, OFS_STATUS, OFS_MODE, OFS_PEAK_LEVEL,
        OFS_CURRENT_LEVEL, OFS_WATERMARK, OFS_READ_POINTER_UPPER,
        OFS_WRITE_POINTER_UPPER}), m, d});
    @(posedge core_clk);
    reg_req <= '{1'b1, 1'b1, w, a, d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic set_dis(input logic v);
    @(posedge core_clk);
    disabled_state <= v;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  always @(posedge core_clk)
    taken <= reg_req.sel & reg_req.enable & ~reg_req.write;

  always @(negedge core_clk)
  begin
    if (taken)
    begin
      n = notes.pop_front();
      chk_rd(reg_rsp.rdata, n[31:0], n[63:32]);
      chk_flag(reg_rsp.slverr, n[64]);
      chk_flag(reg_rsp.ready, 1'b1);
    end
  end

  initial
  begin
    #500us;
    miscompares++;
    complete_run();
  end

  initial
  begin
    r = $urandom(65907);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    acc(1'b0, OFS_MODE, '0, '1);
    acc(1'b0, OFS_WATERMARK, '0, '1);
    acc(1'b0, OFS_PEAK_LEVEL, '0, '1);
    acc(1'b0, OFS_CURRENT_LEVEL, '0, '1);
    acc(1'b0, 12'h040, '0, '1);
    fill_level <= LEVEL_W'(MEM_DEPTH);
    for (int m = 0; m < 4; m++)
    begin
      r = $urandom();
      acc(1'b1, OFS_MODE, {r[31:2], m[1:0]}, '0);
      acc(1'b0, OFS_MODE, {30'h0, m[1:0]}, '1);
      set_dis(1'b0);
      settle(1);
      chk_flag(mode_ctl.circular, m == 0);
      chk_flag(mode_ctl.sw_fifo, m == 1);
      chk_flag(mode_ctl.hw_fifo, m == 2);
      chk_flag(mode_ctl.stall_in, m == 1 || m == 2);
      chk_flag(mode_ctl.drain_out, m == 2);
      chk_flag(mode_ctl.full, m == 1 || m == 2);
      chk_flag(active_mode === m[1:0], 1'b1);
      set_dis(1'b1);
    end
    sys_on <= 1'b1;
    r = $urandom();
    read_pointer_lower <= $urandom();
    write_pointer_lower <= $urandom();
    acc(1'b1, OFS_READ_POINTER_UPPER, r, '0);
    acc(1'b1, OFS_WRITE_POINTER_UPPER, ~r, '0);
    acc(1'b0, OFS_READ_POINTER_UPPER, {24'h0, r[7:0]}, '1);
    acc(1'b0, OFS_WRITE_POINTER_UPPER, {24'h0, ~r[7:0]}, '1);
    settle(0);
    chk_flag(wide_addr === {r[7:0], read_pointer_lower, ~r[7:0], write_pointer_lower}, 1'b1);
    @(posedge core_clk);
    r = $urandom_range(MEM_DEPTH);
    fill_level <= r[LEVEL_W-1:0];
    scatter_gather <= 1'b1;
    acc(1'b1, OFS_CONTROL, 32'h1, '0);
    acc(1'b0, OFS_CURRENT_LEVEL, r, '1);
    settle(0);
    chk_rd(rsp_sys.rdata, '0, '1);
    acc(1'b1, OFS_CONTROL, 32'h0, '0);
    acc(1'b0, OFS_CURRENT_LEVEL, '0, '1);
    fill_level <= 11'd5;
    set_dis(1'b0);
    r = $urandom_range(900) + 100;
    @(posedge core_clk);
    fill_level <= r[LEVEL_W-1:0];
    @(posedge core_clk);
    fill_level <= 11'd7;
    acc(1'b0, OFS_PEAK_LEVEL, r, '1);
    settle(0);
    chk_rd(rsp_sys.rdata, '0, '1);
    acc(1'b0, OFS_PEAK_LEVEL, 32'h7, '1);
    fill_level <= 11'd2;
    locked <= 1'b1;
    acc(1'b0, OFS_PEAK_LEVEL, '0, '1);
    locked <= 1'b0;
    acc(1'b0, OFS_PEAK_LEVEL, 32'h7, '1);
    acc(1'b0, OFS_PEAK_LEVEL, 32'h2, '1);
    disabled_state <= 1'b1;
    fill_level <= 11'd9;
    acc(1'b0, OFS_PEAK_LEVEL, 32'h2, '1);
    acc(1'b0, OFS_PEAK_LEVEL, 32'h2, '1);
    r = $urandom_range(MEM_DEPTH - 2) + 1;
    acc(1'b1, OFS_MODE, 32'h1, '0);
    acc(1'b1, OFS_WATERMARK, r, '0);
    fill_level <= LEVEL_W'(MEM_DEPTH - r - 1);
    set_dis(1'b0);
    settle(3);
    chk_flag(full_out, 1'b0);
    @(posedge core_clk);
    fill_level <= LEVEL_W'(MEM_DEPTH - r);
    settle(3);
    chk_flag(full_out, 1'b1);
    chk_flag(full_sys, 1'b0);
    acc(1'b0, OFS_STATUS, 32'h1, 32'h1);
    fill_level <= '0;
    disabled_state <= 1'b1;
    acc(1'b1, OFS_WATERMARK, MEM_DEPTH - 1, '0);
    set_dis(1'b0);
    settle(3);
    chk_flag(full_out, 1'b0);
    @(posedge core_clk);
    fill_level <= 11'd1;
    settle(3);
    chk_flag(full_out, 1'b1);
    set_dis(1'b1);
    acc(1'b1, OFS_MODE, 32'h0, '0);
    set_dis(1'b0);
    settle(3);
    chk_flag(full_out, 1'b0);
    @(posedge core_clk);
    write_pointer_wrap <= 1'b1;
    @(posedge core_clk);
    write_pointer_wrap <= 1'b0;
    settle(2);
    chk_flag(full_out, 1'b1);
    acc(1'b0, OFS_STATUS, 32'h1, 32'h1);
    settle(3);
    complete_run();
  end
endmodule
